// >>> clk_gate_pkg.sv
package clk_gate_pkg;

	// register offsets inside the system control block
	localparam logic [11:0] RUN_GATE_PERIPHERALS_OFS = 12'h104;
	localparam logic [11:0] RUN_GATE_PORTS_OFS = 12'h108;
	localparam logic [11:0] SLEEP_GATE_PERIPHERALS_OFS = 12'h114;
	localparam logic [11:0] SLEEP_GATE_PORTS_OFS = 12'h118;
	localparam logic [11:0] DEEP_SLEEP_GATE_PERIPHERALS_OFS = 12'h124;
	localparam logic [11:0] DEEP_SLEEP_GATE_PORTS_OFS = 12'h128;
	localparam logic [11:0] RUN_CLOCK_CONFIGURATION_OFS = 12'h1f0;

	// field positions, peripheral group
	localparam int TIMER_ZERO_BIT = 16;
	localparam int TIMER_ONE_BIT = 17;
	localparam int TIMER_TWO_BIT = 18;
	localparam int TWO_WIRE_ZERO_BIT = 12;
	localparam int SYNC_SERIAL_ZERO_BIT = 4;
	localparam int SERIAL_PORT_ONE_BIT = 1;
	localparam int SERIAL_PORT_ZERO_BIT = 0;
	// field positions, port group (a..e from here upward)
	localparam int PORT_A_BIT = 0;
	localparam int PORT_COUNT = 5;
	// automatic low-power gating in the run clock configuration
	localparam int AUTO_LOW_POWER_GATING_BIT = 0;

	// writable bits; everything else is reserved and reads zero
	localparam logic [31:0] PERIPHERALS_MASK = 32'h0007_1013;
	localparam logic [31:0] PORTS_MASK = 32'h0000_001f;
	localparam logic [31:0] CONFIG_MASK = 32'h0000_0001;

	// reset values
	localparam logic [31:0] GATE_RESET = 32'h0000_0000;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP} power_mode_e;

	// one enable per controlled unit
	typedef struct packed {
		logic timer_two_gate;
		logic timer_one_gate;
		logic timer_zero_gate;
		logic two_wire_zero_gate;
		logic sync_serial_zero_gate;
		logic serial_port_one_gate;
		logic serial_port_zero_gate;
		logic [PORT_COUNT-1:0] port_gate;
	} units_s;

	localparam int UNIT_COUNT = 12;

	// peripheral bus request
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

endpackage

// >>> gate_select.sv
`timescale 1ns/1ps
module gate_select (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// selection
	input clk_gate_pkg::power_mode_e mode,
	input wire logic auto_gating,
	// candidate sets
	input clk_gate_pkg::units_s run_set,
	input clk_gate_pkg::units_s sleep_set,
	input clk_gate_pkg::units_s deep_set,
	// registered enables
	output clk_gate_pkg::units_s gate_en
);
	logic [clk_gate_pkg::UNIT_COUNT-1:0] en_r;
	logic [clk_gate_pkg::UNIT_COUNT-1:0] en_nxt;

	// per-unit pick of the set that governs the current mode
	genvar i;
	generate
		for (i = 0; i < clk_gate_pkg::UNIT_COUNT; i++) begin : g_unit
			always_comb begin
				en_nxt[i] = run_set[i];
				if (auto_gating && mode == clk_gate_pkg::MODE_SLEEP) begin
					en_nxt[i] = sleep_set[i];
				end else if (auto_gating &&
						mode == clk_gate_pkg::MODE_DEEP) begin
					en_nxt[i] = deep_set[i];
				end
			end
		end
	endgenerate

	// enables leave a flop so unit clocks never see a glitch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			en_r <= '0;
		end else begin
			en_r <= en_nxt;
		end
	end

	assign gate_en = en_r;

	AST_RUN_WHEN_NO_AUTO: assert property (
		@(posedge clk) disable iff (rst)
		!auto_gating |=> en_r == $past(run_set))
		else $error("run set not applied without auto gating");

endmodule

// >>> peripheral_clock_gating.sv
// Functional notes
// - a one in a gating bit clocks that unit; a zero stops and disables it.
// - an access to a unit whose clock is stopped answers with a bus fault.
// - every gating bit reads zero after reset.
// - run, sleep and deep-sleep sets apply in their own power modes.
// - sleep and deep-sleep sets act only while automatic gating is set.
// - peripheral bit 12 gates two-wire unit zero.
// - peripheral bit 4 gates synchronous serial unit zero.
// - peripheral bits 1 and 0 gate serial ports one and zero.
// - port bits 0 to 4 gate ports a to e.
// - reserved bits are read-only and read zero.
`timescale 1ns/1ps
module peripheral_clock_gating (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	// peripheral bus slave
	input clk_gate_pkg::apb_req_s APB_REQ,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// power mode from the core
	input wire logic SLEEP_REQ,
	input wire logic DEEP_SLEEP_REQ,
	// unit clock enables
	output clk_gate_pkg::units_s UNIT_CLK_EN,
	// accesses aimed at units, and their fault answer
	input clk_gate_pkg::units_s UNIT_ACCESS,
	output clk_gate_pkg::units_s UNIT_FAULT
);
	logic [31:0] run_peri_r, run_peri_nxt;
	logic [31:0] run_port_r, run_port_nxt;
	logic [31:0] slp_peri_r, slp_peri_nxt;
	logic [31:0] slp_port_r, slp_port_nxt;
	logic [31:0] dsl_peri_r, dsl_peri_nxt;
	logic [31:0] dsl_port_r, dsl_port_nxt;
	logic [31:0] cfg_r, cfg_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic err_r, err_nxt;
	clk_gate_pkg::power_mode_e mode_r, mode_nxt;
	logic setup, access, wr, hit;
	logic [31:0] rd_val;
	clk_gate_pkg::units_s run_set, sleep_set, deep_set, gate_en;

	// fold one peripheral word and one port word into unit enables
	function automatic clk_gate_pkg::units_s to_units(
		input logic [31:0] peri,
		input logic [31:0] port
	);
		clk_gate_pkg::units_s u;
		u.timer_two_gate = peri[clk_gate_pkg::TIMER_TWO_BIT];
		u.timer_one_gate = peri[clk_gate_pkg::TIMER_ONE_BIT];
		u.timer_zero_gate = peri[clk_gate_pkg::TIMER_ZERO_BIT];
		u.two_wire_zero_gate = peri[clk_gate_pkg::TWO_WIRE_ZERO_BIT];
		u.sync_serial_zero_gate =
			peri[clk_gate_pkg::SYNC_SERIAL_ZERO_BIT];
		u.serial_port_one_gate =
			peri[clk_gate_pkg::SERIAL_PORT_ONE_BIT];
		u.serial_port_zero_gate =
			peri[clk_gate_pkg::SERIAL_PORT_ZERO_BIT];
		u.port_gate = port[clk_gate_pkg::PORT_A_BIT +:
			clk_gate_pkg::PORT_COUNT];
		return u;
	endfunction

	// bus phase decode; the slave never waits
	assign setup = APB_REQ.psel && !APB_REQ.penable;
	assign access = APB_REQ.psel && APB_REQ.penable;
	assign wr = access && APB_REQ.pwrite && !err_r;
	assign PREADY = 1'b1;

	// address decode and read mux
	always_comb begin
		hit = 1'b1;
		unique case (APB_REQ.paddr)
			clk_gate_pkg::RUN_GATE_PERIPHERALS_OFS: rd_val = run_peri_r;
			clk_gate_pkg::RUN_GATE_PORTS_OFS: rd_val = run_port_r;
			clk_gate_pkg::SLEEP_GATE_PERIPHERALS_OFS: rd_val = slp_peri_r;
			clk_gate_pkg::SLEEP_GATE_PORTS_OFS: rd_val = slp_port_r;
			clk_gate_pkg::DEEP_SLEEP_GATE_PERIPHERALS_OFS: rd_val = dsl_peri_r;
			clk_gate_pkg::DEEP_SLEEP_GATE_PORTS_OFS: rd_val = dsl_port_r;
			clk_gate_pkg::RUN_CLOCK_CONFIGURATION_OFS: rd_val = cfg_r;
			default: begin
				rd_val = clk_gate_pkg::READ_ZERO;
				hit = 1'b0;
			end
		endcase
	end

	// read data and error are caught in the setup phase
	always_comb begin
		rdata_nxt = rdata_r;
		err_nxt = err_r;
		if (setup) begin
			rdata_nxt = rd_val;
			err_nxt = !hit;
		end
	end

	// register writes; reserved bits are masked off at the store
	always_comb begin
		run_peri_nxt = run_peri_r;
		run_port_nxt = run_port_r;
		slp_peri_nxt = slp_peri_r;
		slp_port_nxt = slp_port_r;
		dsl_peri_nxt = dsl_peri_r;
		dsl_port_nxt = dsl_port_r;
		cfg_nxt = cfg_r;
		if (wr) begin
			unique case (APB_REQ.paddr)
				clk_gate_pkg::RUN_GATE_PERIPHERALS_OFS:
					run_peri_nxt = APB_REQ.pwdata &
						clk_gate_pkg::PERIPHERALS_MASK;
				clk_gate_pkg::RUN_GATE_PORTS_OFS:
					run_port_nxt = APB_REQ.pwdata &
						clk_gate_pkg::PORTS_MASK;
				clk_gate_pkg::SLEEP_GATE_PERIPHERALS_OFS:
					slp_peri_nxt = APB_REQ.pwdata &
						clk_gate_pkg::PERIPHERALS_MASK;
				clk_gate_pkg::SLEEP_GATE_PORTS_OFS:
					slp_port_nxt = APB_REQ.pwdata &
						clk_gate_pkg::PORTS_MASK;
				clk_gate_pkg::DEEP_SLEEP_GATE_PERIPHERALS_OFS:
					dsl_peri_nxt = APB_REQ.pwdata &
						clk_gate_pkg::PERIPHERALS_MASK;
				clk_gate_pkg::DEEP_SLEEP_GATE_PORTS_OFS:
					dsl_port_nxt = APB_REQ.pwdata &
						clk_gate_pkg::PORTS_MASK;
				clk_gate_pkg::RUN_CLOCK_CONFIGURATION_OFS:
					cfg_nxt = APB_REQ.pwdata & clk_gate_pkg::CONFIG_MASK;
				default: ;
			endcase
		end
	end

	// power mode, deep sleep has priority over sleep
	always_comb begin
		mode_nxt = clk_gate_pkg::MODE_RUN;
		if (DEEP_SLEEP_REQ) begin
			mode_nxt = clk_gate_pkg::MODE_DEEP;
		end else if (SLEEP_REQ) begin
			mode_nxt = clk_gate_pkg::MODE_SLEEP;
		end
	end

	// state registers
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			run_peri_r <= clk_gate_pkg::GATE_RESET;
			run_port_r <= clk_gate_pkg::GATE_RESET;
			slp_peri_r <= clk_gate_pkg::GATE_RESET;
			slp_port_r <= clk_gate_pkg::GATE_RESET;
			dsl_peri_r <= clk_gate_pkg::GATE_RESET;
			dsl_port_r <= clk_gate_pkg::GATE_RESET;
			cfg_r <= clk_gate_pkg::CONFIG_RESET;
			rdata_r <= clk_gate_pkg::READ_ZERO;
			err_r <= 1'b0;
			mode_r <= clk_gate_pkg::MODE_RUN;
		end else begin
			run_peri_r <= run_peri_nxt;
			run_port_r <= run_port_nxt;
			slp_peri_r <= slp_peri_nxt;
			slp_port_r <= slp_port_nxt;
			dsl_peri_r <= dsl_peri_nxt;
			dsl_port_r <= dsl_port_nxt;
			cfg_r <= cfg_nxt;
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
			mode_r <= mode_nxt;
		end
	end

	assign PRDATA = rdata_r;
	assign PSLVERR = access && err_r;

	// candidate sets for each mode
	assign run_set = to_units(run_peri_r, run_port_r);
	assign sleep_set = to_units(slp_peri_r, slp_port_r);
	assign deep_set = to_units(dsl_peri_r, dsl_port_r);

	gate_select u_select (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.mode(mode_r),
		.auto_gating(cfg_r[clk_gate_pkg::AUTO_LOW_POWER_GATING_BIT]),
		.run_set(run_set),
		.sleep_set(sleep_set),
		.deep_set(deep_set),
		.gate_en(gate_en)
	);

	// a stopped unit runs no clock and faults its accesses
	assign UNIT_CLK_EN = gate_en;
	assign UNIT_FAULT = UNIT_ACCESS & ~gate_en;

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (SYS_RST);

	sequence s_write_run_peri;
		access && APB_REQ.pwrite && !err_r &&
		APB_REQ.paddr == clk_gate_pkg::RUN_GATE_PERIPHERALS_OFS;
	endsequence

	sequence s_run_mode_held;
		(mode_nxt == clk_gate_pkg::MODE_RUN) [*3];
	endsequence

	// a refused write, and a mapped write or read of the run port set
	sequence s_write_refused;
		access && APB_REQ.pwrite && err_r;
	endsequence

	sequence s_write_run_port;
		access && APB_REQ.pwrite && !err_r &&
		APB_REQ.paddr == clk_gate_pkg::RUN_GATE_PORTS_OFS;
	endsequence

	sequence s_read_run_port;
		setup && !APB_REQ.pwrite &&
		APB_REQ.paddr == clk_gate_pkg::RUN_GATE_PORTS_OFS ##1 access;
	endsequence

	AST_FAULT_WHEN_GATED: assert property (
		UNIT_FAULT == (UNIT_ACCESS & ~UNIT_CLK_EN))
		else $error("fault does not follow gating");
	AST_NO_CLOCK_ON_FAULT: assert property (
		(|UNIT_FAULT) |-> (UNIT_FAULT & UNIT_CLK_EN) == '0)
		else $error("faulting unit still clocked");
	AST_RESERVED_ZERO: assert property (
		(run_peri_r & ~clk_gate_pkg::PERIPHERALS_MASK) == '0 &&
		(slp_peri_r & ~clk_gate_pkg::PERIPHERALS_MASK) == '0 &&
		(dsl_peri_r & ~clk_gate_pkg::PERIPHERALS_MASK) == '0 &&
		(run_port_r & ~clk_gate_pkg::PORTS_MASK) == '0 &&
		(slp_port_r & ~clk_gate_pkg::PORTS_MASK) == '0 &&
		(dsl_port_r & ~clk_gate_pkg::PORTS_MASK) == '0 &&
		(cfg_r & ~clk_gate_pkg::CONFIG_MASK) == '0)
		else $error("reserved bit holds a one");
	AST_RESET_ZERO: assert property (
		$fell(SYS_RST) |-> UNIT_CLK_EN == '0 && run_peri_r == '0 &&
		run_port_r == '0 && slp_peri_r == '0 && slp_port_r == '0 &&
		dsl_peri_r == '0 && dsl_port_r == '0 && cfg_r == '0)
		else $error("gating not zero after reset");
	AST_TIMER_BITS: assert property (
		s_write_run_peri ##1 s_run_mode_held |->
		UNIT_CLK_EN.timer_two_gate == run_peri_r[18] &&
		UNIT_CLK_EN.timer_zero_gate == run_peri_r[16])
		else $error("timer gate bits misplaced");
	AST_SERIAL_BITS: assert property (
		mode_r == clk_gate_pkg::MODE_RUN |=>
		UNIT_CLK_EN.serial_port_one_gate == $past(run_peri_r[1]) &&
		UNIT_CLK_EN.serial_port_zero_gate == $past(run_peri_r[0]))
		else $error("serial port gate bits misplaced");
	AST_MISC_BITS: assert property (
		mode_r == clk_gate_pkg::MODE_RUN |=>
		UNIT_CLK_EN.two_wire_zero_gate == $past(run_peri_r[12]) &&
		UNIT_CLK_EN.sync_serial_zero_gate == $past(run_peri_r[4]))
		else $error("two-wire or sync serial gate misplaced");
	AST_PORT_BITS: assert property (
		mode_r == clk_gate_pkg::MODE_RUN |=>
		UNIT_CLK_EN.port_gate == $past(run_port_r[4:0]))
		else $error("port gate bits misplaced");
	AST_DEEP_SET: assert property (
		mode_r == clk_gate_pkg::MODE_DEEP && cfg_r[0] |=>
		UNIT_CLK_EN.port_gate == $past(dsl_port_r[4:0]))
		else $error("deep sleep set not applied");
	AST_SLEEP_SET: assert property (
		mode_r == clk_gate_pkg::MODE_SLEEP && cfg_r[0] |=>
		UNIT_CLK_EN.timer_one_gate == $past(slp_peri_r[17]))
		else $error("sleep set not applied");
	AST_UNMAPPED_ERR: assert property (
		setup && !hit ##1 access |-> PSLVERR)
		else $error("unmapped access not refused");

	// whole-set selection and bus path checks
	AST_WRITE_LANDS: assert property (
		s_write_run_port |=>
		run_port_r == ($past(APB_REQ.pwdata) & clk_gate_pkg::PORTS_MASK))
		else $error("run port write lost or reserved bit kept");
	AST_READ_DATA: assert property (
		s_read_run_port |-> PRDATA == run_port_r && !PSLVERR)
		else $error("run port read data wrong");
	AST_REFUSED_WRITE: assert property (
		s_write_refused |=> $stable(run_peri_r) && $stable(run_port_r) &&
		$stable(slp_peri_r) && $stable(slp_port_r) &&
		$stable(dsl_peri_r) && $stable(dsl_port_r) && $stable(cfg_r))
		else $error("refused write changed a register");
	AST_RUN_SET_WHOLE: assert property (
		mode_r == clk_gate_pkg::MODE_RUN |=> UNIT_CLK_EN == $past(run_set))
		else $error("run set not applied while running");
	AST_SLEEP_WHOLE: assert property (
		mode_r == clk_gate_pkg::MODE_SLEEP && cfg_r[0] |=>
		UNIT_CLK_EN == $past(sleep_set))
		else $error("sleep set not applied whole");
	AST_DEEP_WHOLE: assert property (
		mode_r == clk_gate_pkg::MODE_DEEP && cfg_r[0] |=>
		UNIT_CLK_EN == $past(deep_set))
		else $error("deep sleep set not applied whole");
	AST_NO_AUTO_RUN_SET: assert property (
		mode_r != clk_gate_pkg::MODE_RUN && !cfg_r[0] |=>
		UNIT_CLK_EN == $past(run_set))
		else $error("low-power set used without auto gating");
	AST_DEEP_WINS: assert property (
		DEEP_SLEEP_REQ |=> mode_r == clk_gate_pkg::MODE_DEEP)
		else $error("deep sleep request not taken");

endmodule

// >>> core_model.sv
`timescale 1ns/1ps
module core_model (
	// clock
	input wire logic clk,
	// bus request toward the block
	output clk_gate_pkg::apb_req_s req
);
	// idle bus at time zero
	initial begin
		req = '0;
	end
	// setup then access phase; ready is always high, so one access cycle
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		#1;
		req = '{1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		#1;
		req.penable = 1'b1;
		@(posedge clk);
		#1;
		// released data shows the inverse, never a stale copy
		req = '{1'b0, 1'b0, 1'b0, 12'h000, ~d};
	endtask
endmodule

// >>> peripheral_clock_gating_bench.sv
`timescale 1ns/1ps
module peripheral_clock_gating_bench;
	logic clk, rst, slp, deep, ustb, pready, pslverr;
	logic [31:0] prdata, lf, auto, d;
	clk_gate_pkg::apb_req_s req;
	clk_gate_pkg::units_s en, acc, flt;
	logic [31:0] shadow [6];
	logic [32:0] rq [$];
	logic [23:0] uq [$];
	logic [1:0] wq [$];
	int n_fail, cmp_count;
	localparam logic [11:0] OFS [7] = '{12'h104, 12'h108, 12'h114,
		12'h118, 12'h124, 12'h128, 12'h1f0};

	core_model i_core (.clk(clk), .req(req));
	peripheral_clock_gating i_dut (.CORE_CLK(clk), .SYS_RST(rst),
		.APB_REQ(req), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .SLEEP_REQ(slp), .DEEP_SLEEP_REQ(deep),
		.UNIT_CLK_EN(en), .UNIT_ACCESS(acc), .UNIT_FAULT(flt));

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// unit enables from a peripheral word and a port word
	function automatic clk_gate_pkg::units_s map(input logic [31:0] p, q);
		return {p[18], p[17], p[16], p[12], p[4], p[1], p[0], q[4:0]};
	endfunction
	// deep sleep wins; low-power sets only with auto gating
	function automatic clk_gate_pkg::units_s exp_en();
		int k;
		k = (auto[0] && deep) ? 4 : (auto[0] && slp) ? 2 : 0;
		return map(shadow[k], shadow[k + 1]);
	endfunction

	task automatic cmp_read(input logic [32:0] e);
		cmp_count++;
		if ({pslverr, prdata} !== e) begin
			n_fail++;
			$display("ERROR %0t read %h/%b exp %h", $time, prdata,
				pslverr, e);
		end
	endtask
	task automatic cmp_units(input logic [23:0] e);
		cmp_count++;
		if ({en, flt} !== e) begin
			n_fail++;
			$display("ERROR %0t units %h/%h exp %h", $time, en, flt, e);
		end
	endtask
	task automatic cmp_write(input logic [1:0] e);
		cmp_count++;
		if ({pready, pslverr} !== e) begin
			n_fail++;
			$display("ERROR %0t write %b/%b exp %b", $time, pready,
				pslverr, e);
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] v,
		input logic err);
		rq.push_back({err, v});
		i_core.xfer(1'b0, a, lf);
	endtask
	// write with its expected ready and error answer
	task automatic wr(input logic [11:0] a, input logic [31:0] v,
		input logic err);
		wq.push_back({1'b1, err});
		i_core.xfer(1'b1, a, v);
	endtask
	// random unit accesses against the expected enables
	task automatic units();
		lf = nxt(lf);
		@(posedge clk);
		#1;
		acc = lf[11:0];
		uq.push_back({exp_en(), lf[11:0] & ~exp_en()});
		ustb = 1'b1;
		@(posedge clk);
		#1;
		ustb = 1'b0;
	endtask
	task automatic end_of_test();
		// results still owed count as misses
		if (rq.size() + uq.size() + wq.size() != 0) begin
			n_fail++;
		end
		$display("n_fail %0d cmp_count %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// monitor: oldest note against each result as it appears
	always @(posedge clk) begin
		if (req.psel && req.penable && !req.pwrite && rq.size() > 0) begin
			cmp_read(rq.pop_front());
		end
		if (ustb && uq.size() > 0) begin
			cmp_units(uq.pop_front());
		end
		if (req.psel && req.penable && req.pwrite && wq.size() > 0) begin
			cmp_write(wq.pop_front());
		end
	end

	// watchdog
	initial begin
		#200000;
		n_fail++;
		end_of_test();
	end

	task automatic after_reset();
		foreach (shadow[i]) shadow[i] = '0;
		auto = '0;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int i = 0; i < 7; i++) rd(OFS[i], 32'h0, 1'b0);
		units();
	endtask

	initial begin
		rst = 1'b1;
		slp = 1'b0;
		deep = 1'b0;
		acc = '0;
		ustb = 1'b0;
		lf = 32'hc506;
		d = '0;
		n_fail = 0;
		cmp_count = 0;
		after_reset();
		// unmapped offset: fault answer, write dropped
		wr(12'h10c, 32'hffff_ffff, 1'b1);
		rd(12'h10c, 32'h0, 1'b1);
		for (int r = 0; r < 6; r++) begin
			// write each gating register, all ones in round 0 and random words after, and read it back
			for (int i = 0; i < 6; i++) begin
				lf = nxt(lf);
				d = (r == 0) ? 32'hffff_ffff : lf;
				shadow[i] = d & (i[0] ? clk_gate_pkg::PORTS_MASK :
					clk_gate_pkg::PERIPHERALS_MASK);
				wr(OFS[i], d, 1'b0);
				rd(OFS[i], shadow[i], 1'b0);
			end
			lf = nxt(lf);
			d = {lf[31:1], r[0]};
			auto = d & clk_gate_pkg::CONFIG_MASK;
			wr(OFS[6], d, 1'b0);
			rd(OFS[6], auto, 1'b0);
			// every mode, deep and sleep together included
			for (int m = 0; m < 4; m++) begin
				slp = m[0];
				deep = m[1];
				repeat (3) @(posedge clk);
				#1;
				units();
			end
		end
		// second reset in mid-run
		rst = 1'b1;
		after_reset();
		end_of_test();
	end
endmodule
